// >>> design/tco_timer_compare.v
// Top level: APB register file, tick gating, flags and two channels
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "tco_regs.vh"
module tco_timer_compare #(
    parameter WIDTH = 8
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        timer_tick_in,
    input  wire        irq_ack_ovf,
    input  wire        irq_ack_a,
    input  wire        irq_ack_b,
    output wire        irq_ovf,
    output wire        irq_a,
    output wire        irq_b,
    input  wire        output_pin_direction_bit_a,
    input  wire        output_pin_direction_bit_b,
    input  wire        port_data_a,
    input  wire        port_data_b,
    output wire        pin_out_a,
    output wire        pin_out_b,
    output wire        pin_oe_n_a,
    output wire        pin_oe_n_b
);
    reg  [11:0]      ctrl_q;
    reg  [2:0]       flags_q;
    reg  [2:0]       flags_d;
    reg  [2:0]       ien_q;
    reg              block_q;
    reg              pend_a_q;
    reg              pend_b_q;
    wire [WIDTH-1:0] timer_count;
    wire [WIDTH-1:0] cmp_a;
    wire [WIDTH-1:0] cmp_b;
    wire             down;
    wire             at_top;
    wire             at_bottom;
    wire             ovf_ev;
    wire             match_a;
    wire             match_b;

    wire       acc      = psel & penable;
    wire       wr       = acc & pwrite;
    wire [2:0] waveform_mode_select = ctrl_q[`TCO_CTRL_WGM_LSB +: 3];
    wire [2:0] clock_source_select  = ctrl_q[`TCO_CTRL_CS_LSB +: 3];
    wire [1:0] action_a = ctrl_q[`TCO_CTRL_COMA_LSB +: 2];
    wire [1:0] action_b = ctrl_q[`TCO_CTRL_COMB_LSB +: 2];
    // Clock source zero stops the timer clock
    wire       tick     = timer_tick_in & (clock_source_select != 3'h0); // [R21]
    wire       pwm_mode = (waveform_mode_select[1:0] == 2'h1) |
                          (waveform_mode_select[1:0] == 2'h3); // [R5]
    wire       wr_count = wr & (paddr == `TCO_ADDR_COUNT);
    wire       wr_force = wr & (paddr == `TCO_ADDR_FORCE);
    // Eight aligned words from offset zero are mapped
    wire       known    = (paddr[11:5] == 7'h00) & (paddr[1:0] == 2'h0);
    // Fixed-top modes take all ones as top, others take compare A
    wire [WIDTH-1:0] top_value = waveform_mode_select[2] ? cmp_a
                                                         : `TCO_CNT_MAX;
    // Fast PWM loads at bottom; phase correct at top
    wire reload = tick & ((waveform_mode_select[1:0] == 2'h3) ? at_bottom
                                                              : at_top);

    assign pready  = 1'b1;
    assign pslverr = acc & ~known;

    tco_counter #(
        .WIDTH(WIDTH)
    ) u_cnt (
        .pclk                 (pclk),
        .presetn              (presetn),
        .tick                 (tick),
        .waveform_mode_select (waveform_mode_select),
        .top_value            (top_value),
        .wr_count             (wr_count),
        .wr_data              (pwdata[WIDTH-1:0]),
        .timer_count          (timer_count),
        .down_q               (down),
        .at_top               (at_top),
        .at_bottom            (at_bottom),
        .overflow_event       (ovf_ev)
    );

    tco_channel #(
        .WIDTH(WIDTH)
    ) u_cha (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .timer_count              (timer_count),
        .tick                     (tick),
        .pwm_mode                 (pwm_mode),
        .reload                   (reload),
        .block                    (block_q),
        .phase_down               (down),
        .at_bottom                (at_bottom),
        .output_action_field      (action_a),
        .force_compare_strobe     (wr_force & pwdata[`TCO_FORCE_A]),
        .wr_cmp                   (wr & (paddr == `TCO_ADDR_CMP_A)),
        .wr_data                  (pwdata[WIDTH-1:0]),
        .output_pin_direction_bit (output_pin_direction_bit_a),
        .port_data                (port_data_a),
        .compare_value            (cmp_a),
        .match_event              (match_a),
        .pin_out                  (pin_out_a),
        .pin_oe_n                 (pin_oe_n_a)
    );

    tco_channel #(
        .WIDTH(WIDTH)
    ) u_chb (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .timer_count              (timer_count),
        .tick                     (tick),
        .pwm_mode                 (pwm_mode),
        .reload                   (reload),
        .block                    (block_q),
        .phase_down               (down),
        .at_bottom                (at_bottom),
        .output_action_field      (action_b),
        .force_compare_strobe     (wr_force & pwdata[`TCO_FORCE_B]),
        .wr_cmp                   (wr & (paddr == `TCO_ADDR_CMP_B)),
        .wr_data                  (pwdata[WIDTH-1:0]),
        .output_pin_direction_bit (output_pin_direction_bit_b),
        .port_data                (port_data_b),
        .compare_value            (cmp_b),
        .match_event              (match_b),
        .pin_out                  (pin_out_b),
        .pin_oe_n                 (pin_oe_n_b)
    );

    // Control and enables; block lasts until the next timer tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= 12'h000;
            ien_q   <= 3'h0;
            block_q <= 1'b0;
        end else begin
            if (wr && paddr == `TCO_ADDR_CTRL) begin
                ctrl_q <= pwdata[11:0];
            end
            if (wr && paddr == `TCO_ADDR_IEN) begin
                ien_q <= pwdata[2:0];
            end
            if (wr_count) begin
                block_q <= 1'b1; // [R9]
            end else if (tick) begin
                block_q <= 1'b0;
            end
        end
    end

    // Flag is set one timer cycle after the match
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_a_q <= 1'b0;
            pend_b_q <= 1'b0;
        end else begin
            if (match_a) begin
                pend_a_q <= 1'b1;
            end else if (tick) begin
                pend_a_q <= 1'b0;
            end
            if (match_b) begin
                pend_b_q <= 1'b1;
            end else if (tick) begin
                pend_b_q <= 1'b0;
            end
        end
    end

    // Flags: clears by write-one or service, hardware set wins
    always @* begin
        flags_d = flags_q;
        if (wr && paddr == `TCO_ADDR_FLAGS) begin
            flags_d = flags_q & ~pwdata[2:0]; // [R4]
        end
        flags_d = flags_d & ~{irq_ack_b, irq_ack_a, irq_ack_ovf}; // [R3]
        if (ovf_ev) begin
            flags_d[`TCO_BIT_OVF] = 1'b1; // [R20]
        end
        if (pend_a_q && tick) begin
            flags_d[`TCO_BIT_CMPA] = 1'b1; // [R2]
        end
        if (pend_b_q && tick) begin
            flags_d[`TCO_BIT_CMPB] = 1'b1; // [R2]
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= 3'h0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign irq_ovf = flags_q[`TCO_BIT_OVF]  & ien_q[`TCO_BIT_OVF]; // [R3]
    assign irq_a   = flags_q[`TCO_BIT_CMPA] & ien_q[`TCO_BIT_CMPA];
    assign irq_b   = flags_q[`TCO_BIT_CMPB] & ien_q[`TCO_BIT_CMPB];

    // Read data registered in the setup phase, ready for the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `TCO_ADDR_CTRL:   prdata <= {20'h00000, ctrl_q};
                `TCO_ADDR_COUNT:  prdata <= {24'h000000, timer_count};
                `TCO_ADDR_CMP_A:  prdata <= {24'h000000, cmp_a};
                `TCO_ADDR_CMP_B:  prdata <= {24'h000000, cmp_b};
                `TCO_ADDR_FLAGS:  prdata <= {29'h0, flags_q};
                `TCO_ADDR_IEN:    prdata <= {29'h0, ien_q};
                `TCO_ADDR_STATUS: prdata <= {29'h0, pwm_mode, down, block_q};
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// >>> design/tco_regs.vh
// Register map, field positions, reset values and modes of the compare unit
//
// Behaviour
// (R1) Compare count with both values continuously
// (R2) Flag sets one timer cycle after match
// (R3) Enabled flag requests interrupt, cleared on service
// (R4) Writing one clears flag, zero ignored
// (R5) PWM modes buffer compare values
// (R6) Buffer copies to active at top/bottom
// (R7) CPU access reaches buffer or active
// (R8) Force strobe acts like match, no flag
// (R9) Counter write blocks next cycle's matches
// (R10) Software avoids writing count equal compare
// (R11) Software sets output before pin direction
// (R12) Output state kept across mode change
// (R13) Action bits unbuffered, effective next match
// (R14) Nonzero action field overrides port data
// (R15) Direction bit still gates the pin
// (R16) Action zero leaves output unchanged
// (R17) Counting depends only on mode bits
// (R18) Action: set/clear/toggle or PWM polarity
// (R19) Mode 0 counts up, wraps FF to 00
// (R20) Overflow flag set when count becomes zero
// (R21) Clock select zero stops, CPU access kept
// (R22) CPU counter write beats count
// (R23) Force ignored in PWM modes
`ifndef TCO_REGS_VH
`define TCO_REGS_VH

// Byte offsets on APB
`define TCO_ADDR_CTRL     12'h000
`define TCO_ADDR_FORCE    12'h004
`define TCO_ADDR_COUNT    12'h008
`define TCO_ADDR_CMP_A    12'h00c
`define TCO_ADDR_CMP_B    12'h010
`define TCO_ADDR_FLAGS    12'h014
`define TCO_ADDR_IEN      12'h018
`define TCO_ADDR_STATUS   12'h01c

// Control register fields
`define TCO_CTRL_WGM_LSB  0
`define TCO_CTRL_CS_LSB   4
`define TCO_CTRL_COMA_LSB 8
`define TCO_CTRL_COMB_LSB 10
`define TCO_CTRL_RST      32'h0000_0000

// Flag and enable bit positions
`define TCO_BIT_OVF       0
`define TCO_BIT_CMPA      1
`define TCO_BIT_CMPB      2

// Force register bits
`define TCO_FORCE_A       0
`define TCO_FORCE_B       1

// Waveform modes; modes 5 and 7 take their top from compare A, the others use all ones
`define TCO_WGM_NORMAL    3'h0
`define TCO_WGM_PC_FF     3'h1
`define TCO_WGM_CTC       3'h2
`define TCO_WGM_FAST_FF   3'h3
`define TCO_WGM_PC_OCR    3'h5
`define TCO_WGM_FAST_OCR  3'h7
`define TCO_CNT_MAX       8'hff
`define TCO_CNT_BOTTOM    8'h00

`endif

// >>> design/tco_channel.v
// One compare channel: buffered compare value, match logic, output state
`timescale 1ns/10ps
`include "tco_regs.vh"
module tco_channel #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] timer_count,
    input  wire             tick,
    input  wire             pwm_mode,
    input  wire             reload,
    input  wire             block,
    input  wire             phase_down,
    input  wire             at_bottom,
    input  wire [1:0]       output_action_field,
    input  wire             force_compare_strobe,
    input  wire             wr_cmp,
    input  wire [WIDTH-1:0] wr_data,
    input  wire             output_pin_direction_bit,
    input  wire             port_data,
    output wire [WIDTH-1:0] compare_value,
    output wire             match_event,
    output reg              pin_out,
    output wire             pin_oe_n
);
    reg [WIDTH-1:0] active_q;
    reg [WIDTH-1:0] buffer_q;
    reg             state_q;
    reg             state_d;
    wire            eq;
    wire            take;

    // CPU sees the buffer only when buffering is on
    assign compare_value = pwm_mode ? buffer_q : active_q; // [R7]
    assign eq = (timer_count == active_q); // [R1]
    // Match counts only on timer ticks, not after a counter write
    assign take = eq & tick & ~block; // [R9]
    assign match_event = take;

    // Active and buffer registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= {WIDTH{1'b0}};
            buffer_q <= {WIDTH{1'b0}};
        end else begin
            if (wr_cmp) begin
                buffer_q <= wr_data; // [R5]
            end
            if (wr_cmp && !pwm_mode) begin
                active_q <= wr_data; // [R7]
            end else if (pwm_mode && reload) begin
                active_q <= buffer_q; // [R6]
            end
        end
    end

    // Next output state from match, force or PWM edge
    always @* begin
        state_d = state_q;
        if (!pwm_mode) begin
            if (take || force_compare_strobe) begin // [R8] [R23]
                case (output_action_field) // [R18]
                    2'h1: state_d = ~state_q;
                    2'h2: state_d = 1'b0;
                    2'h3: state_d = 1'b1;
                    default: state_d = state_q; // [R16]
                endcase
            end
        end else if (output_action_field[1]) begin
            // Non-inverted clears on match counting up, sets on match counting down and at bottom
            if (take) begin
                state_d = output_action_field[0] ^ phase_down;
            end else if (at_bottom && tick) begin
                state_d = ~output_action_field[0];
            end
        end else if (output_action_field[0] && take) begin
            state_d = ~state_q;
        end
    end

    // State survives mode changes; no reset on mode write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= 1'b0;
        end else begin
            state_q <= state_d; // [R12] [R13]
        end
    end

    // Pin override by action field, direction from port bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
        end else if (output_action_field != 2'h0) begin
            pin_out <= state_d; // [R14]
        end else begin
            pin_out <= port_data;
        end
    end
    assign pin_oe_n = ~output_pin_direction_bit; // [R15]
endmodule

// >>> design/tco_counter.v
// Eight-bit counter with mode-driven sequence and CPU write priority
`timescale 1ns/10ps
`include "tco_regs.vh"
module tco_counter #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             tick,
    input  wire [2:0]       waveform_mode_select,
    input  wire [WIDTH-1:0] top_value,
    input  wire             wr_count,
    input  wire [WIDTH-1:0] wr_data,
    output reg  [WIDTH-1:0] timer_count,
    output reg              down_q,
    output wire             at_top,
    output wire             at_bottom,
    output wire             overflow_event
);
    wire phase = (waveform_mode_select[1:0] == 2'h1);
    wire fast  = (waveform_mode_select[1:0] == 2'h3);
    wire clear_on_match_mode   = (waveform_mode_select == `TCO_WGM_CTC);

    assign at_top    = (timer_count == top_value);
    assign at_bottom = (timer_count == `TCO_CNT_BOTTOM);
    // Overflow: wrap to zero, or bottom turn in phase correct mode
    assign overflow_event = tick & !wr_count & (phase ? (at_bottom & down_q)
                          : (fast ? at_top : (timer_count == `TCO_CNT_MAX)));

    // Sequence chosen by mode bits alone
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count <= {WIDTH{1'b0}};
            down_q <= 1'b0;
        end else if (wr_count) begin
            timer_count <= wr_data; // [R22]
        end else if (tick) begin // [R21]
            if (phase) begin
                if (at_top) begin
                    down_q <= 1'b1;
                    timer_count <= timer_count - 1'b1;
                end else if (down_q && at_bottom) begin
                    down_q <= 1'b0;
                    timer_count <= timer_count + 1'b1;
                end else if (down_q) begin
                    timer_count <= timer_count - 1'b1;
                end else begin
                    timer_count <= timer_count + 1'b1;
                end
            end else if ((fast || clear_on_match_mode) && at_top) begin
                down_q <= 1'b0;
                timer_count <= `TCO_CNT_BOTTOM;
            end else begin
                down_q <= 1'b0;
                timer_count <= timer_count + 1'b1; // [R17] [R19]
            end
        end
    end
endmodule

// >>> sim/tco_timer_compare_properties.sv
// Port-level assertions for the timer compare unit
`timescale 1ns/10ps
`include "tco_regs.vh"
module tco_timer_compare_properties #(
    parameter WIDTH = 8
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        timer_tick_in,
    input wire        irq_ack_a,
    input wire        irq_a,
    input wire        output_pin_direction_bit_a,
    input wire        output_pin_direction_bit_b,
    input wire        port_data_a,
    input wire        pin_out_a,
    input wire        pin_oe_n_a,
    input wire        pin_oe_n_b
);
    reg  [11:0] ctrl_q;
    reg  [2:0]  ien_q;
    reg  [2:0]  ev_q;
    wire        wr_en;
    wire        flag_wr;
    wire        out_ev;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Bus write decode for the shadow copies
    assign wr_en   = psel & penable & pwrite;
    assign flag_wr = wr_en && paddr == `TCO_ADDR_FLAGS;
    assign out_ev  = timer_tick_in | (wr_en && (paddr == `TCO_ADDR_FORCE
                     || paddr == `TCO_ADDR_CTRL));
    // Shadow registers and recent output events
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 12'h000;
            ien_q  <= 3'h0;
            ev_q   <= 3'h0;
        end else begin
            if (wr_en && paddr == `TCO_ADDR_CTRL)
                ctrl_q <= pwdata[11:0];
            if (wr_en && paddr == `TCO_ADDR_IEN)
                ien_q <= pwdata[2:0];
            ev_q <= {ev_q[1:0], out_ev};
        end
    end
    chk_oe_dir_a: assert property (pin_oe_n_a == !output_pin_direction_bit_a)
        else $error("pin enable a does not follow direction");
    chk_oe_dir_b: assert property (pin_oe_n_b == !output_pin_direction_bit_b)
        else $error("pin enable b does not follow direction");
    chk_hold_override: assert property ($past(ctrl_q[9:8]) != 2'b00 &&
        $past(ctrl_q[9:8], 2) != 2'b00 && ev_q[2:0] == 3'b000
        |-> $stable(pin_out_a)) else $error("pin a moved with no event");
    chk_port_pass: assert property ($past(presetn) &&
        $past(ctrl_q[9:8]) == 2'b00 |-> pin_out_a == $past(port_data_a))
        else $error("pin a not taken from port data");
    chk_irq_masked: assert property (irq_a |-> ien_q[1])
        else $error("request a raised while disabled");
    chk_ack_clears: assert property (irq_a && irq_ack_a && !timer_tick_in
        |=> !irq_a) else $error("service did not clear flag a");
    chk_one_clears: assert property (flag_wr && pwdata[1] && !timer_tick_in
        |=> !irq_a) else $error("writing one left flag a set");
    chk_zero_keeps: assert property (flag_wr && !pwdata[1] && irq_a
        && !irq_ack_a |=> irq_a) else $error("writing zero cleared flag a");
    chk_set_on_tick: assert property ((!timer_tick_in || ctrl_q[6:4] == 3'h0)
        && !irq_a && !(wr_en && paddr == `TCO_ADDR_IEN) |=> !irq_a)
        else $error("flag a set without a timer cycle");
    cov_service: cover property (irq_a && irq_ack_a);
    cov_clear_pending: cover property (flag_wr && irq_a);
    cov_force: cover property (wr_en && paddr == `TCO_ADDR_FORCE);
endmodule

bind tco_timer_compare tco_timer_compare_properties #(.WIDTH(WIDTH)) u_props (.*);

// >>> sim/tco_cpu_port_model.sv
// Interrupt servicing and port pin model outside the compare unit
`timescale 1ns/10ps
module tco_cpu_port_model #(
    parameter logic [7:0] SERVICE_DELAY = 8'h04
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        service_en,
    input  wire  [2:0] irq,
    output wire  [2:0] irq_ack,
    input  wire  [1:0] pin_out,
    input  wire  [1:0] pin_oe_n,
    output wire  [1:0] level
);
    logic [7:0] wait_q;
    logic [2:0] ack_q;
    logic [1:0] last_q;
    // Service pending requests after a delay with a one-cycle acknowledge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 8'h00;
            ack_q  <= 3'h0;
        end else if (ack_q != 3'h0 || irq == 3'h0 || !service_en) begin
            wait_q <= 8'h00;
            ack_q  <= 3'h0;
        end else if (wait_q == SERVICE_DELAY) begin
            ack_q <= irq;
        end else begin
            wait_q <= wait_q + 8'h01;
        end
    end
    assign irq_ack = ack_q;
    // Remember the wire so a released pin never keeps its last level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            last_q <= 2'b00;
        else
            last_q <= level;
    end
    assign level = (pin_oe_n & ~last_q) | (~pin_oe_n & pin_out);
endmodule

// >>> sim/tco_timer_compare_tb_top.sv
// Self-checking bench for the timer compare unit
`timescale 1ns/10ps
`include "tco_regs.vh"
module tco_timer_compare_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, tick_in;
    logic        dir_a, dir_b, pd_a, pd_b, svc, err_seen, irq_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0]  rows [7];
    wire  [31:0] prdata;
    wire         pready, pslverr, irq_ovf, irq_a, irq_b;
    wire         pin_out_a, pin_out_b, pin_oe_n_a, pin_oe_n_b;
    wire  [2:0]  ack;
    wire  [1:0]  level;
    int          fail_count, check_count, i;

    tco_timer_compare u_tco_timer_compare (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_tick_in(tick_in),
        .irq_ack_ovf(ack[0]), .irq_ack_a(ack[1]), .irq_ack_b(ack[2]),
        .irq_ovf(irq_ovf), .irq_a(irq_a), .irq_b(irq_b),
        .output_pin_direction_bit_a(dir_a), .output_pin_direction_bit_b(dir_b),
        .port_data_a(pd_a), .port_data_b(pd_b), .pin_out_a(pin_out_a),
        .pin_out_b(pin_out_b), .pin_oe_n_a(pin_oe_n_a), .pin_oe_n_b(pin_oe_n_b)
    );
    tco_cpu_port_model u_tco_cpu_port_model (
        .pclk(pclk), .presetn(presetn), .service_en(svc),
        .irq({irq_b, irq_a, irq_ovf}), .irq_ack(ack),
        .pin_out({pin_out_b, pin_out_a}), .pin_oe_n({pin_oe_n_b, pin_oe_n_a}),
        .level(level)
    );
    // Bus clock and a record of a raised request A
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) if (irq_a === 1'b1) irq_seen <= 1'b1;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask
    // One bus transfer: setup, then access until ready, then release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20) begin
            fail_count++;
            end_of_test();
        end
        rd = prdata;
        err_seen = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk32($sformatf("reg %h", a), e, rd);
    endtask
    // Hold the timer enable for n bus cycles
    task automatic tick(input int n);
        @(posedge pclk);
        tick_in <= 1'b1;
        repeat (n) @(posedge pclk);
        tick_in <= 1'b0;
    endtask
    initial begin
        #2000000;
        fail_count++;
        end_of_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, tick_in, svc} = 6'h0;
        {dir_a, dir_b, pd_a, pd_b, irq_seen} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fail_count = 0;
        check_count = 0;
        rows = '{4'b1010, 4'b0111, 4'b0100, 4'b1101, 4'b0000, 4'b0011, 4'b0100};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 8; i++)
            rdchk(12'(i * 4), 32'h0);
        rdchk(12'h020, 32'h0);
        chk1("slverr", 1'b1, err_seen);
        // Output state is set up before the pins become outputs
        apb(1'b1, `TCO_ADDR_CTRL, 32'h0a00);
        apb(1'b1, `TCO_ADDR_FORCE, 32'h3);
        {dir_a, dir_b} <= 2'b11;
        // Rows: action field, port data, expected pin after a forced match
        for (i = 0; i < 7; i++) begin
            {pd_a, pd_b} <= {2{rows[i][1]}};
            apb(1'b1, `TCO_ADDR_CTRL, {20'h0, rows[i][3:2], rows[i][3:2], 8'h0});
            apb(1'b1, `TCO_ADDR_FORCE, 32'h3);
            repeat (3) @(posedge pclk);
            chk1("pin_a", rows[i][0], pin_out_a);
            chk1("pin_b", rows[i][0], pin_out_b);
            chk1("level_a", rows[i][0], level[0]);
        end
        rdchk(`TCO_ADDR_FLAGS, 32'h0);
        // Stopped clock keeps count; normal mode wraps and flags overflow
        apb(1'b1, `TCO_ADDR_COUNT, 32'hfd);
        tick(3);
        rdchk(`TCO_ADDR_COUNT, 32'hfd);
        apb(1'b1, `TCO_ADDR_CTRL, 32'h10);
        tick(2);
        rdchk(`TCO_ADDR_COUNT, 32'hff);
        rdchk(`TCO_ADDR_FLAGS, 32'h0);
        tick(1);
        rdchk(`TCO_ADDR_COUNT, 32'h0);
        rdchk(`TCO_ADDR_FLAGS, 32'h1);
        tick(2);
        rdchk(`TCO_ADDR_FLAGS, 32'h7);
        apb(1'b1, `TCO_ADDR_IEN, 32'h7);
        apb(1'b1, `TCO_ADDR_FLAGS, 32'h0);
        rdchk(`TCO_ADDR_FLAGS, 32'h7);
        apb(1'b1, `TCO_ADDR_FLAGS, 32'h2);
        rdchk(`TCO_ADDR_FLAGS, 32'h5);
        apb(1'b1, `TCO_ADDR_FLAGS, 32'h5);
        rdchk(`TCO_ADDR_FLAGS, 32'h0);
        apb(1'b1, `TCO_ADDR_IEN, 32'h0);
        // Count written equal to compare while stopped: the match is lost
        apb(1'b1, `TCO_ADDR_CTRL, 32'h0);
        apb(1'b1, `TCO_ADDR_CMP_A, 32'h12);
        apb(1'b1, `TCO_ADDR_CMP_B, 32'h40);
        apb(1'b1, `TCO_ADDR_COUNT, 32'h12);
        apb(1'b1, `TCO_ADDR_CTRL, 32'h10);
        tick(2);
        rdchk(`TCO_ADDR_FLAGS, 32'h0);
        // Serviced request clears its flag
        svc <= 1'b1;
        apb(1'b1, `TCO_ADDR_IEN, 32'h2);
        apb(1'b1, `TCO_ADDR_COUNT, 32'h10);
        tick(4);
        repeat (12) @(posedge pclk);
        chk1("irq_seen", 1'b1, irq_seen);
        rdchk(`TCO_ADDR_FLAGS, 32'h0);
        // Bus write beats a count in the same cycle
        tick_in <= 1'b1;
        apb(1'b1, `TCO_ADDR_COUNT, 32'h30);
        tick_in <= 1'b0;
        rdchk(`TCO_ADDR_COUNT, 32'h30);
        // Mode change keeps the output; force ignored in pulse modes
        apb(1'b1, `TCO_ADDR_CTRL, 32'h0303);
        apb(1'b1, `TCO_ADDR_FORCE, 32'h1);
        repeat (3) @(posedge pclk);
        chk1("pin_a", 1'b0, pin_out_a);
        // Buffered compare reaches the comparator only at top or bottom
        apb(1'b1, `TCO_ADDR_COUNT, 32'h20);
        apb(1'b1, `TCO_ADDR_CMP_A, 32'h25);
        rdchk(`TCO_ADDR_CMP_A, 32'h25);
        apb(1'b1, `TCO_ADDR_FLAGS, 32'h7);
        apb(1'b1, `TCO_ADDR_CTRL, 32'h0313);
        tick(224);
        apb(1'b0, `TCO_ADDR_FLAGS, 32'h0);
        chk1("flag_a", 1'b0, rd[1]);
        apb(1'b1, `TCO_ADDR_FLAGS, 32'h7);
        tick(22);
        apb(1'b0, `TCO_ADDR_FLAGS, 32'h0);
        chk1("flag_a", 1'b0, rd[1]);
        tick(20);
        apb(1'b0, `TCO_ADDR_FLAGS, 32'h0);
        chk1("flag_a", 1'b1, rd[1]);
        end_of_test();
    end
endmodule
